// >>> address_data_pin_mux.sv
// Pin mux for upper address, clock monitor and low data pins
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module address_data_pin_mux #(
  parameter int PB_PINS  = 4,
  parameter int PF_PINS  = 7,
  parameter int CTRL_W   = 3
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [7:0]           awaddr,
  // AXI4-Lite write data
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  // AXI4-Lite write response
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  // AXI4-Lite read
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [7:0]           araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  // External memory interface core side
  input  wire logic                 emi_bus_active,
  input  wire logic [PB_PINS-1:0]   emi_addr_hi,
  input  wire logic [CTRL_W-1:0]    emi_ctrl,
  input  wire logic [PF_PINS-1:0]   emi_data_out,
  input  wire logic                 emi_data_drive,
  output logic [PF_PINS-1:0]        emi_data_in,
  // Clocks to monitor
  input  wire logic                 prescaler_clock,
  input  wire logic                 system_clock_main,
  input  wire logic                 system_clock_second,
  input  wire logic                 oscillator_clock,
  // Port B pins 4..7
  input  wire logic [PB_PINS-1:0]   pb_pad_i,
  output logic [PB_PINS-1:0]        pb_pad_o,
  output logic [PB_PINS-1:0]        pb_pad_oe,
  // Port F pins 9..15 (data 0..6)
  input  wire logic [PF_PINS-1:0]   pf_pad_i,
  output logic [PF_PINS-1:0]        pf_pad_o,
  output logic [PF_PINS-1:0]        pf_pad_oe,
  output logic [PF_PINS-1:0]        pf_pad_pullup,
  // Memory control pins
  output logic [CTRL_W-1:0]         ctrl_pad_o,
  output logic [CTRL_W-1:0]         ctrl_pad_oe
);

  // Widths that the register map cannot serve are refused
  if (PB_PINS != 4) begin : g_pb_check
    $error("PB_PINS must be 4");
  end
  if (PF_PINS < 1 || PF_PINS > 7) begin : g_pf_check
    $error("PF_PINS must be 1 to 7");
  end
  if (CTRL_W < 1 || CTRL_W > 8) begin : g_ctrl_check
    $error("CTRL_W must be 1 to 8");
  end

  localparam int PFL = pin_mux_pkg::PF_LSB;

  // Register state
  logic                 drive_hold_bit;
  logic [PB_PINS-1:0]   portb_function_select;
  logic [PB_PINS-1:0]   clock_out_select_register;
  logic [PB_PINS-1:0]   pb_dir;
  logic [PB_PINS-1:0]   pb_out;
  logic [PB_PINS-1:0]   pb_in;
  logic [PF_PINS-1:0]   pf_gpio;
  logic [PF_PINS-1:0]   pf_dir;
  logic [PF_PINS-1:0]   pf_out;
  logic [PF_PINS-1:0]   pf_in;
  logic [PF_PINS-1:0]   portf_pullup_enable;

  // Bus strobes
  logic                 wr_en;
  logic [7:0]           wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic                 wr_err;
  logic                 rd_en;
  logic [7:0]           rd_addr;
  logic [31:0]          rd_data;
  logic                 rd_err;

  // Derived pin control
  pin_mux_pkg::pin_func_t pb_func [PB_PINS];
  logic [PB_PINS-1:0]   clk_mon;
  logic                 bus_drive;
  logic                 full_addr;
  logic [CTRL_W-1:0]    ctrl_q;
  logic                 ctrl_oe_q;
  logic [PF_PINS-1:0]   data_hold;
  pin_mux_pkg::pin_t    pb_pad [PB_PINS];
  pin_mux_pkg::pin_t    pf_pad [PF_PINS];

  axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // Write decode; the input and status words are read-only
  always_comb begin
    if (wr_addr == pin_mux_pkg::OFF_PB_IN ||
        wr_addr == pin_mux_pkg::OFF_PF_IN) begin
      wr_err = 1'b1;
    end else begin
      wr_err = wr_addr[1:0] != 2'b00 ||
               wr_addr > pin_mux_pkg::OFF_PF_PULLUP;
    end
  end

  // Bus control: drive-hold defaults to floating when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_hold_bit <= pin_mux_pkg::RST_DRV_HOLD;
    end else if (wr_en && wr_strb[0] &&
                 wr_addr == pin_mux_pkg::OFF_BUS_CTRL) begin
      drive_hold_bit <= wr_data[pin_mux_pkg::DRV_HOLD_BIT];
    end
  end

  // Port B function, clock-out select, direction and output latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      portb_function_select     <= '0;
      clock_out_select_register <= '0;
      pb_dir <= '0;
      pb_out <= '0;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == pin_mux_pkg::OFF_PB_FSEL) begin
        portb_function_select <= wr_data[PB_PINS-1:0];
      end
      if (wr_addr == pin_mux_pkg::OFF_CLKO_SEL) begin
        clock_out_select_register <= wr_data[PB_PINS-1:0];
      end
      if (wr_addr == pin_mux_pkg::OFF_PB_DIR) begin
        pb_dir <= wr_data[PB_PINS-1:0];
      end
      if (wr_addr == pin_mux_pkg::OFF_PB_OUT) begin
        pb_out <= wr_data[PB_PINS-1:0];
      end
    end
  end

  // Port F registers sit in bits 15:9, byte lane 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pf_gpio             <= '0;
      pf_dir              <= '0;
      pf_out              <= '0;
      portf_pullup_enable <=
        pin_mux_pkg::RST_PF_PULLUP[PFL +: PF_PINS];
    end else if (wr_en && wr_strb[1]) begin
      if (wr_addr == pin_mux_pkg::OFF_PF_GPIO) begin
        pf_gpio <= wr_data[PFL +: PF_PINS];
      end
      if (wr_addr == pin_mux_pkg::OFF_PF_DIR) begin
        pf_dir <= wr_data[PFL +: PF_PINS];
      end
      if (wr_addr == pin_mux_pkg::OFF_PF_OUT) begin
        pf_out <= wr_data[PFL +: PF_PINS];
      end
      // bit 9+n set enables pin n pull-up, clear turns it off
      if (wr_addr == pin_mux_pkg::OFF_PF_PULLUP) begin
        portf_pullup_enable <= wr_data[PFL +: PF_PINS];
      end
    end
  end

  // Pad input sampling, also fed back to the memory core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_in       <= '0;
      pf_in       <= '0;
      emi_data_in <= '0;
    end else begin
      pb_in       <= pb_pad_i;
      pf_in       <= pf_pad_i;
      emi_data_in <= pf_pad_i;
    end
  end

  // Read decode
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (rd_addr == pin_mux_pkg::OFF_BUS_CTRL) begin
      rd_data[pin_mux_pkg::DRV_HOLD_BIT] = drive_hold_bit;
    end else if (rd_addr == pin_mux_pkg::OFF_PB_FSEL) begin
      rd_data[PB_PINS-1:0] = portb_function_select;
    end else if (rd_addr == pin_mux_pkg::OFF_CLKO_SEL) begin
      rd_data[PB_PINS-1:0] = clock_out_select_register;
    end else if (rd_addr == pin_mux_pkg::OFF_PB_DIR) begin
      rd_data[PB_PINS-1:0] = pb_dir;
    end else if (rd_addr == pin_mux_pkg::OFF_PB_OUT) begin
      rd_data[PB_PINS-1:0] = pb_out;
    end else if (rd_addr == pin_mux_pkg::OFF_PB_IN) begin
      rd_data[PB_PINS-1:0] = pb_in;
    end else if (rd_addr == pin_mux_pkg::OFF_PF_GPIO) begin
      rd_data[PFL +: PF_PINS] = pf_gpio;
    end else if (rd_addr == pin_mux_pkg::OFF_PF_DIR) begin
      rd_data[PFL +: PF_PINS] = pf_dir;
    end else if (rd_addr == pin_mux_pkg::OFF_PF_OUT) begin
      rd_data[PFL +: PF_PINS] = pf_out;
    end else if (rd_addr == pin_mux_pkg::OFF_PF_IN) begin
      rd_data[PFL +: PF_PINS] = pf_in;
    end else if (rd_addr == pin_mux_pkg::OFF_PF_PULLUP) begin
      rd_data[PFL +: PF_PINS] = portf_pullup_enable;
    end else if (rd_addr == pin_mux_pkg::OFF_STATUS) begin
      rd_data[pin_mux_pkg::ST_FULL_ADDR] = full_addr;
      rd_data[pin_mux_pkg::ST_BUS_ACT]   = emi_bus_active;
    end else begin
      rd_err = 1'b1;
    end
  end

  assign clk_mon = {oscillator_clock, system_clock_second,
                    system_clock_main, prescaler_clock};

  // idle bus floats unless drive-hold is set
  assign bus_drive = emi_bus_active || drive_hold_bit;

  // Port B pins: function decode and pad cell
  for (genvar i = 0; i < PB_PINS; i++) begin : g_pb
    always_comb begin
      if (!portb_function_select[i]) begin
        pb_func[i] = pin_mux_pkg::FN_GPIO;
      end else if (clock_out_select_register[i]) begin
        pb_func[i] = pin_mux_pkg::FN_CLK;
      end else begin
        pb_func[i] = pin_mux_pkg::FN_ADDR;
      end
    end

    logic per_o;
    logic per_oe;

    always_comb begin
      case (pb_func[i])
        pin_mux_pkg::FN_CLK: begin
          per_o  = clk_mon[i];
          per_oe = 1'b1;
        end
        pin_mux_pkg::FN_ADDR: begin
          per_o  = emi_addr_hi[i];
          per_oe = bus_drive;
        end
        default: begin
          per_o  = 1'b0;
          per_oe = 1'b0;
        end
      endcase
    end

    pin_cell u_cell (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .periph_sel (portb_function_select[i]),
      .gpio_out   (pb_out[i]),
      .gpio_dir   (pb_dir[i]),
      .periph_out (per_o),
      .periph_oe  (per_oe),
      .pad        (pb_pad[i])
    );

    assign pb_pad_o[i]  = pb_pad[i].o;
    assign pb_pad_oe[i] = pb_pad[i].oe && aresetn;
  end

  assign full_addr = (portb_function_select == '1) &&
                     (clock_out_select_register == '0);

  // Last driven data, kept on the pins while idle with drive-hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_hold <= '0;
    end else if (emi_bus_active && emi_data_drive) begin
      data_hold <= emi_data_out;
    end
  end

  // Port F pins: data bus unless switched to GPIO
  for (genvar j = 0; j < PF_PINS; j++) begin : g_pf
    logic d_o;
    logic d_oe;

    always_comb begin
      if (emi_bus_active) begin
        d_o  = emi_data_out[j];
        d_oe = emi_data_drive;
      end else begin
        d_o  = data_hold[j];
        d_oe = drive_hold_bit;
      end
    end

    pin_cell u_cell (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .periph_sel (!pf_gpio[j]),
      .gpio_out   (pf_out[j]),
      .gpio_dir   (pf_dir[j]),
      .periph_out (d_o),
      .periph_oe  (d_oe),
      .pad        (pf_pad[j])
    );

    assign pf_pad_o[j]      = pf_pad[j].o;
    assign pf_pad_oe[j]     = pf_pad[j].oe && aresetn;
    assign pf_pad_pullup[j] = portf_pullup_enable[j] || !aresetn;
  end

  // Memory control pins share the idle float behaviour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= '0;
      ctrl_oe_q <= 1'b0;
    end else begin
      ctrl_q    <= emi_ctrl;
      ctrl_oe_q <= bus_drive;
    end
  end

  assign ctrl_pad_o  = ctrl_q;
  assign ctrl_pad_oe = {CTRL_W{ctrl_oe_q && aresetn}};

endmodule : address_data_pin_mux

// >>> pin_mux_pkg.sv
// Shared constants and types for the address/data pin mux
package pin_mux_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_BUS_CTRL  = 8'h00;
  localparam logic [7:0] OFF_PB_FSEL   = 8'h04;
  localparam logic [7:0] OFF_CLKO_SEL  = 8'h08;
  localparam logic [7:0] OFF_PB_DIR    = 8'h0C;
  localparam logic [7:0] OFF_PB_OUT    = 8'h10;
  localparam logic [7:0] OFF_PB_IN     = 8'h14;
  localparam logic [7:0] OFF_PF_GPIO   = 8'h18;
  localparam logic [7:0] OFF_PF_DIR    = 8'h1C;
  localparam logic [7:0] OFF_PF_OUT    = 8'h20;
  localparam logic [7:0] OFF_PF_IN     = 8'h24;
  localparam logic [7:0] OFF_PF_PULLUP = 8'h28;
  localparam logic [7:0] OFF_STATUS    = 8'h2C;

  // Field positions
  localparam int DRV_HOLD_BIT = 0;
  localparam int PF_LSB       = 9;
  localparam int ST_FULL_ADDR = 0;
  localparam int ST_BUS_ACT   = 1;

  // Values after reset
  localparam logic [15:0] RST_PF_PULLUP = 16'hFE00;
  localparam logic        RST_DRV_HOLD  = 1'b0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // One pin as seen by the pad
  typedef struct packed {
    logic o;
    logic oe;
  } pin_t;

  // Function of one port B pin
  typedef enum logic [2:0] {
    FN_GPIO = 3'b001,
    FN_ADDR = 3'b010,
    FN_CLK  = 3'b100
  } pin_func_t;

endpackage : pin_mux_pkg

// >>> pin_cell.sv
// One pad cell: picks GPIO or peripheral drive, registered
`timescale 1ns/1ps
module pin_cell (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Selection
  input  wire logic         periph_sel,
  // GPIO side
  input  wire logic         gpio_out,
  input  wire logic         gpio_dir,
  // Peripheral side
  input  wire logic         periph_out,
  input  wire logic         periph_oe,
  // Pad drive
  output pin_mux_pkg::pin_t pad
);

  // Registered pad drive, released while reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad <= '0;
    end else if (periph_sel) begin
      pad.o  <= periph_out;
      pad.oe <= periph_oe;
    end else begin
      pad.o  <= gpio_out;
      pad.oe <= gpio_dir;
    end
  end

endmodule : pin_cell

// >>> axil_slave.sv
// AXI4-Lite slave front end: turns bus traffic into strobes
`timescale 1ns/1ps
module axil_slave (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // Write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // Read address and data
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Register side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic             rd_en,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);

  logic aw_have;
  logic w_have;

  // Each channel is taken alone; the write fires once both are held
  assign awready = !aw_have && !bvalid;
  assign wready  = !w_have && !bvalid;
  assign wr_en   = aw_have && w_have && !bvalid;
  assign arready = !rvalid;
  assign rd_en   = arvalid && arready;
  assign rd_addr = araddr;

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_have <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_en) begin
      aw_have <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have  <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_have  <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_have <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= pin_mux_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? pin_mux_pkg::RESP_SLVERR
                       : pin_mux_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read response, data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= pin_mux_pkg::RESP_OKAY;
    end else if (rd_en) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_err ? pin_mux_pkg::RESP_SLVERR
                       : pin_mux_pkg::RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : axil_slave

// >>> address_data_pin_mux_sva.sv
// Port-level checker for the address/data pin mux
`timescale 1ns/1ps
module address_data_pin_mux_sva #(
  parameter int PB_PINS = 4,
  parameter int PF_PINS = 7,
  parameter int CTRL_W  = 3
) (
  // Clock, reset and write channels
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               awvalid,
  input wire logic               awready,
  input wire logic [7:0]         awaddr,
  input wire logic               wvalid,
  input wire logic               wready,
  input wire logic [31:0]        wdata,
  input wire logic               bvalid,
  input wire logic [1:0]         bresp,
  // Memory core side and monitored clocks
  input wire logic               emi_bus_active,
  input wire logic [PB_PINS-1:0] emi_addr_hi,
  input wire logic [CTRL_W-1:0]  emi_ctrl,
  input wire logic [PF_PINS-1:0] emi_data_out,
  input wire logic               emi_data_drive,
  input wire logic [PF_PINS-1:0] emi_data_in,
  input wire logic               prescaler_clock,
  input wire logic               system_clock_main,
  input wire logic               system_clock_second,
  input wire logic               oscillator_clock,
  // Pads
  input wire logic [PB_PINS-1:0] pb_pad_o,
  input wire logic [PB_PINS-1:0] pb_pad_oe,
  input wire logic [PF_PINS-1:0] pf_pad_i,
  input wire logic [PF_PINS-1:0] pf_pad_o,
  input wire logic [PF_PINS-1:0] pf_pad_oe,
  input wire logic [PF_PINS-1:0] pf_pad_pullup,
  input wire logic [CTRL_W-1:0]  ctrl_pad_o,
  input wire logic [CTRL_W-1:0]  ctrl_pad_oe
);
  logic [7:0]         wa;
  logic [31:0]        wd;
  logic               bv_q;
  logic               hold;
  logic [PB_PINS-1:0] fsel, clko, amask, cmask;
  logic [PF_PINS-1:0] pfg, dmask;

  // Shadow config; lags the register one edge, as the pads do
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      hold <= 1'b0;
      fsel <= '0;
      clko <= '0;
      pfg  <= '0;
    end else begin
      bv_q <= bvalid;
      if (awvalid && awready) wa <= awaddr;
      if (wvalid && wready) wd <= wdata;
      if (bvalid && !bv_q && bresp == pin_mux_pkg::RESP_OKAY) begin
        case (wa)
          pin_mux_pkg::OFF_BUS_CTRL: hold <= wd[pin_mux_pkg::DRV_HOLD_BIT];
          pin_mux_pkg::OFF_PB_FSEL:  fsel <= wd[PB_PINS-1:0];
          pin_mux_pkg::OFF_CLKO_SEL: clko <= wd[PB_PINS-1:0];
          pin_mux_pkg::OFF_PF_GPIO:  pfg  <= wd[pin_mux_pkg::PF_LSB +: PF_PINS];
          default: ;
        endcase
      end
    end
  end

  // Pins per function
  assign amask = fsel & ~clko;
  assign cmask = fsel & clko;
  assign dmask = ~pfg;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_no_drive: assert property (disable iff (1'b0) !aresetn |->
    (pb_pad_oe == '0 && pf_pad_oe == '0 && ctrl_pad_oe == '0))
    else $error("pad driven during reset");
  a_reset_pull_up: assert property (disable iff (1'b0)
    !aresetn |-> &pf_pad_pullup) else $error("pull-up off in reset");
  a_gpio_after_reset: assert property ($rose(aresetn) |->
    pb_pad_oe == '0 [*3]) else $error("port B not input after reset");
  a_addr_bits: assert property ($past(aresetn) |->
    ((pb_pad_o ^ $past(emi_addr_hi)) & amask) == '0)
    else $error("address pin wrong");
  a_clock_order: assert property ($past(aresetn) |-> ((pb_pad_o ^
    $past({oscillator_clock, system_clock_second, system_clock_main,
    prescaler_clock})) & cmask) == '0) else $error("clock pin wrong");
  a_addr_float: assert property ($past(aresetn) |-> (pb_pad_oe &
    amask) == (amask & {PB_PINS{$past(emi_bus_active) | hold}}))
    else $error("address pin drive wrong");
  a_clock_drive: assert property ($past(aresetn) |->
    (pb_pad_oe & cmask) == cmask) else $error("clock pin not driven");
  a_ctrl_follow: assert property ($past(aresetn) |->
    ctrl_pad_o == $past(emi_ctrl) &&
    ctrl_pad_oe == {CTRL_W{$past(emi_bus_active) | hold}})
    else $error("control pin wrong");
  a_data_float: assert property ($past(aresetn) |-> (pf_pad_oe &
    dmask) == (dmask & {PF_PINS{$past(emi_bus_active) ?
    $past(emi_data_drive) : hold}})) else $error("data drive wrong");
  a_data_write: assert property ($past(aresetn) &&
    $past(emi_bus_active) |-> ((pf_pad_o ^ $past(emi_data_out)) &
    dmask) == '0) else $error("data pin wrong");
  a_data_sample: assert property ($past(aresetn) |->
    emi_data_in == $past(pf_pad_i)) else $error("data sample wrong");

  c_addr: cover property (amask != '0 && emi_bus_active);
  c_clock: cover property (cmask != '0);
  c_data: cover property (dmask != '0 && emi_data_drive);
endmodule : address_data_pin_mux_sva

bind address_data_pin_mux address_data_pin_mux_sva #(.PB_PINS(PB_PINS),
  .PF_PINS(PF_PINS), .CTRL_W(CTRL_W)) chk (.*);

// >>> ext_memory_model.sv
// Behavioural external memory on data pins 0..6
`timescale 1ns/1ps
module ext_memory_model (
  // Clock
  input  wire logic       aclk,
  // Strobes and data pads from the device
  input  wire logic [2:0] ctrl_o,
  input  wire logic [2:0] ctrl_oe,
  input  wire logic [6:0] pad_o,
  input  wire logic [6:0] pad_oe,
  input  wire logic [6:0] pull_en,
  // Level on the data pins
  output logic [6:0]      pad_i
);
  logic [6:0] mem  = 7'h55;
  logic [6:0] last = 7'h00;
  logic       sel;
  // Strobe 0 selects, strobe 1 marks a write
  assign sel = ctrl_oe[0] & ctrl_o[0];
  always @(posedge aclk) begin
    if (sel && ctrl_o[1]) mem <= pad_o;
    last <= pad_i;
  end
  // pulled up, else inverse of last level
  always_comb begin
    for (int i = 0; i < 7; i++)
      pad_i[i] = pad_oe[i] ? pad_o[i] : (sel && !ctrl_o[1]) ? mem[i] :
                 pull_en[i] ? 1'b1 : ~last[i];
  end
endmodule : ext_memory_model

// >>> address_data_pin_mux_tb.sv
// Self-checking bench for the address/data pin mux
`timescale 1ns/1ps
module address_data_pin_mux_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, emi_bus_active;
  logic        emi_data_drive, prescaler_clock, system_clock_main;
  logic        system_clock_second, oscillator_clock, hold;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, emi_addr_hi, pb_pad_i, pb_pad_o, pb_pad_oe;
  logic [3:0]  fs, ck, pd, po;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  emi_ctrl, ctrl_pad_o, ctrl_pad_oe;
  logic [6:0]  emi_data_out, emi_data_in, pf_pad_i, pf_pad_o, pf_pad_oe;
  logic [6:0]  pf_pad_pullup, gg, gd, go, m;
  int          n_mismatch, checks_done, seed, k;

  address_data_pin_mux DUT (.*);
  ext_memory_model mem_model (.aclk(aclk), .ctrl_o(ctrl_pad_o),
    .ctrl_oe(ctrl_pad_oe), .pad_o(pf_pad_o), .pad_oe(pf_pad_oe),
    .pull_en(pf_pad_pullup), .pad_i(pf_pad_i));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= v;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Random memory-core traffic and clock levels
  task automatic emi_rand;
    @(posedge aclk);
    {emi_bus_active, emi_data_drive, emi_addr_hi, emi_ctrl} <=
      9'($random(seed));
    {prescaler_clock, system_clock_main, system_clock_second,
     oscillator_clock} <= 4'($random(seed));
    emi_data_out <= 7'($random(seed));
    pb_pad_i <= 4'($random(seed));
  endtask : emi_rand

  // Expected port B drive and level
  function automatic logic [7:0] pb_exp;
    logic [3:0] c;
    c = {oscillator_clock, system_clock_second, system_clock_main,
         prescaler_clock};
    return {(fs & (ck | {4{emi_bus_active | hold}})) | (~fs & pd),
            (fs & ck & c) | (fs & ~ck & emi_addr_hi) | (~fs & po)};
  endfunction : pb_exp

  // Main sequence
  initial begin
    seed = 32'h2d76_7ee9;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, pb_pad_i} = '0;
    wstrb = 4'hf;
    {emi_bus_active, emi_data_drive, emi_addr_hi, emi_ctrl} = '0;
    {prescaler_clock, system_clock_main, system_clock_second} = '0;
    {oscillator_clock, emi_data_out, n_mismatch, checks_done} = '0;
    repeat (12) @(posedge aclk);
    #1;
    check(32'({pb_pad_oe, pf_pad_oe, ctrl_pad_oe}), 32'h0);
    check(32'(pf_pad_pullup), 32'h7f);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(pin_mux_pkg::OFF_PB_FSEL);
    check(d, 32'h0);
    rd(pin_mux_pkg::OFF_PF_GPIO);
    check(d, 32'h0);
    rd(pin_mux_pkg::OFF_PF_PULLUP);
    check(d, 32'(pin_mux_pkg::RST_PF_PULLUP));
    rd(8'h30);
    check(32'(r), 32'(pin_mux_pkg::RESP_SLVERR));
    wr(pin_mux_pkg::OFF_PB_IN, 32'hffff_ffff);
    check(32'(r), 32'(pin_mux_pkg::RESP_SLVERR));
    for (k = 0; k < 7; k++) begin
      wr(pin_mux_pkg::OFF_PF_PULLUP, ~(32'h1 << (k + 9)));
      check(32'(pf_pad_pullup), 32'h7f ^ (32'h1 << k));
    end
    for (k = 0; k < 12; k++) begin
      {fs, ck, pd, po, hold} = 17'($random(seed));
      {gg, gd, go} = 21'($random(seed));
      // Corners: full address bus, then all four clocks
      if (k < 2) {fs, ck} = {4'hf, {4{k[0]}}};
      // software sets drive-hold at random in each pass
      wr(pin_mux_pkg::OFF_BUS_CTRL, 32'(hold));
      wr(pin_mux_pkg::OFF_PB_FSEL, 32'(fs));
      wr(pin_mux_pkg::OFF_CLKO_SEL, 32'(ck));
      wr(pin_mux_pkg::OFF_PB_DIR, 32'(pd));
      wr(pin_mux_pkg::OFF_PB_OUT, 32'(po));
      wr(pin_mux_pkg::OFF_PF_GPIO, 32'(gg) << 9);
      wr(pin_mux_pkg::OFF_PF_DIR, 32'(gd) << 9);
      wr(pin_mux_pkg::OFF_PF_OUT, 32'(go) << 9);
      repeat (8) emi_rand();
      repeat (2) @(posedge aclk);
      #1;
      m = gg | {7{emi_bus_active}};
      check(32'({pb_pad_oe, pb_pad_o}), 32'(pb_exp()));
      check(32'(pf_pad_oe), 32'((gg & gd) | (~gg & {7{emi_bus_active ?
        emi_data_drive : hold}})));
      check(32'(pf_pad_o & m), 32'(((gg & go) | (~gg & emi_data_out)) & m));
      check(32'(ctrl_pad_oe), 32'({3{emi_bus_active | hold}}));
      rd(pin_mux_pkg::OFF_STATUS);
      check(32'(d[1:0]), 32'({emi_bus_active, fs == 4'hf && ck == 4'h0}));
    end
    // Memory round trip on the data bus
    wr(pin_mux_pkg::OFF_PF_GPIO, 32'h0);
    @(posedge aclk);
    {emi_bus_active, emi_data_drive, emi_ctrl} <= 5'b1_1011;
    emi_data_out <= 7'h2a;
    repeat (3) @(posedge aclk);
    {emi_data_drive, emi_ctrl} <= 4'b0001;
    repeat (4) @(posedge aclk);
    #1;
    check(32'(emi_data_in), 32'h2a);
    // Reset in mid-run with pins configured to drive
    wr(pin_mux_pkg::OFF_BUS_CTRL, 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    #1;
    check(32'({pb_pad_oe, pf_pad_oe, ctrl_pad_oe}), 32'h0);
    check(32'(pf_pad_pullup), 32'h7f);
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    tally_and_finish();
  end

  // Watchdog, about thirty times the expected run
  initial begin
    #200_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : address_data_pin_mux_tb
